/* design/dsoc_strap_ctrl.sv */
// Lock and self-test reporting, strap capture and parallel output gating
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "dsoc_regs.svh"

module dsoc_strap_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DSOC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic powerdown_n,
    input wire logic self_test_on,
    input wire logic rx_pll_locked,
    input wire logic payload_error,
    input wire logic rec_pixel_clock,
    input wire dsoc_pkg::dsoc_pix_type rec_pix,
    input wire logic [23:0] rgb_in,
    output logic [23:0] rgb_out,
    output logic rgb_oe,
    output logic line_sync,
    output logic frame_sync,
    output logic pixel_valid,
    output logic sync_oe,
    output logic pixel_clock_out,
    output logic pixel_clock_oe,
    output logic pll_acquired,
    input wire logic pass_in,
    output logic bist_ok_flag,
    output logic pass_oe,
    output dsoc_pkg::dsoc_cfg_type cfg_active,
    output logic control_filter_on,
    output logic spread_band_low
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    localparam int NSYNC = 29;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    logic [NSYNC-1:0] async_in;
    dsoc_pkg::dsoc_pix_type pix1_ff;
    dsoc_pkg::dsoc_pix_type pix2_ff;

    // Straps, pass pin, controls and link clock share one two-stage chain
    assign async_in = {rgb_in, pass_in, powerdown_n, self_test_on, rx_pll_locked,
        rec_pixel_clock};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            pix1_ff <= '0;
            pix2_ff <= '0;
        end else begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
            pix1_ff <= rec_pix;
            pix2_ff <= pix1_ff;
        end
    end

    logic [23:0] strap_s;
    logic pass_s;
    logic pd_n_s;
    logic test_s;
    logic lock_s;
    logic lclk_s;
    assign strap_s = sync2_ff[28:5];
    assign pass_s = sync2_ff[4];
    assign pd_n_s = sync2_ff[3];
    assign test_s = sync2_ff[2];
    assign lock_s = sync2_ff[1];
    assign lclk_s = sync2_ff[0];

    logic [7:0] str_r;
    logic [7:0] str_g;
    logic [7:0] str_b;
    assign str_r = strap_s[23:16];
    assign str_g = strap_s[15:8];
    assign str_b = strap_s[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Power-up sequencing and strap capture

    dsoc_pkg::dsoc_state_type state_ff;
    dsoc_pkg::dsoc_state_type nxt_state;
    dsoc_pkg::dsoc_cfg_type strap_ff;
    dsoc_pkg::dsoc_cfg_type strap_now;

    always_comb begin
        strap_now = '0;
        strap_now.link_mode = {str_b[`DSOC_STR_MODE1_B], str_b[`DSOC_STR_MODE0_B]};
        strap_now.bit_map_choice = {str_r[`DSOC_STR_MAP1_R], str_r[`DSOC_STR_MAP0_R]};
        strap_now.rx_gain_boost_setting = str_g[`DSOC_STR_GAIN3_G:`DSOC_STR_GAIN0_G];
        strap_now.pattern_clock_choice = str_g[`DSOC_STR_OSC2_G:`DSOC_STR_OSC0_G];
        strap_now.spread_clock_gen = str_r[`DSOC_STR_SSC3_R:`DSOC_STR_SSC0_R];
        strap_now.spread_low_band = str_b[`DSOC_STR_LOWBAND_B];
        strap_now.data_edge_rate = str_b[`DSOC_STR_DRATE_B];
        strap_now.pixclk_edge_rate = str_b[`DSOC_STR_PRATE_B];
        strap_now.sleep_output_choice = str_b[`DSOC_STR_SLEEP_B];
        strap_now.strobe_polarity = str_b[`DSOC_STR_POL_B];
        strap_now.hold_outputs_zero = pass_s;
    end

    always_comb begin
        case (state_ff)
            dsoc_pkg::DSOC_OFF: nxt_state = pd_n_s ? dsoc_pkg::DSOC_RUN : dsoc_pkg::DSOC_OFF;
            dsoc_pkg::DSOC_RUN: nxt_state = pd_n_s ? dsoc_pkg::DSOC_RUN : dsoc_pkg::DSOC_SLEEP;
            dsoc_pkg::DSOC_SLEEP: nxt_state = pd_n_s ? dsoc_pkg::DSOC_RUN : dsoc_pkg::DSOC_SLEEP;
            default: nxt_state = dsoc_pkg::DSOC_OFF;
        endcase
    end

    // Straps are taken once, while every shared pin is still released
    wire capture = (state_ff == dsoc_pkg::DSOC_OFF) && pd_n_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= dsoc_pkg::DSOC_OFF;
            strap_ff <= `DSOC_CFG_RESET;
        end else begin
            state_ff <= nxt_state;
            if (capture) begin
                strap_ff <= strap_now;
            end
        end
    end

    wire powered = (state_ff != dsoc_pkg::DSOC_OFF);
    wire running = (state_ff == dsoc_pkg::DSOC_RUN) && pd_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_ctrl = (paddr == `DSOC_OFS_CTRL);
    wire hit_ovr = (paddr == `DSOC_OFS_CFG_OVR);
    wire hit_eff = (paddr == `DSOC_OFS_CFG_EFF);
    wire hit_stat = (paddr == `DSOC_OFS_STATUS);
    wire hit_any = hit_ctrl || hit_ovr || hit_eff || hit_stat;
    wire wr_ctrl = access && pwrite && hit_ctrl;
    wire wr_ovr = access && pwrite && hit_ovr;
    wire restart_wr = wr_ctrl && pwdata[`DSOC_CTRL_RESTART_B];

    logic release_ff;
    logic ovr_valid_ff;
    dsoc_pkg::dsoc_cfg_type ovr_ff;
    logic [31:0] prdata_ff;

    // Control registers clear while powered down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            release_ff <= 1'b0;
            ovr_valid_ff <= 1'b0;
            ovr_ff <= `DSOC_CFG_RESET;
        end else if (!pd_n_s) begin
            release_ff <= 1'b0;
            ovr_valid_ff <= 1'b0;
            ovr_ff <= `DSOC_CFG_RESET;
        end else begin
            if (wr_ctrl) begin
                release_ff <= pwdata[`DSOC_CTRL_RELEASE_B];
            end
            if (wr_ovr) begin
                ovr_ff <= pwdata[`DSOC_CFG_W-1:0];
                ovr_valid_ff <= 1'b1;
            end
        end
    end

    dsoc_pkg::dsoc_cfg_type cfg;
    assign cfg = ovr_valid_ff ? ovr_ff : strap_ff;
    assign cfg_active = cfg;
    assign control_filter_on = (cfg.link_mode == 2'h1);
    assign spread_band_low = (cfg.spread_clock_gen != 4'h0) && cfg.spread_low_band;

    wire held = cfg.hold_outputs_zero && !release_ff;
    logic bist_ok_ff;
    logic [31:0] status_word;
    assign status_word = {27'h0, ovr_valid_ff, held, powered, pll_acquired, bist_ok_ff};

    logic [31:0] rd_mux;
    assign rd_mux = hit_ctrl ? {31'h0, release_ff} :
        hit_ovr ? {11'h0, ovr_ff} :
        hit_eff ? {11'h0, cfg} :
        hit_stat ? status_word : 32'h0;

    // Read data is taken in the setup phase so it leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (setup) begin
            prdata_ff <= pwrite ? 32'h0 : rd_mux;
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = access && !hit_any;

    ////////////////////////////////////////////////////////////////////////////
    // Self-test result

    logic test_d_ff;
    wire test_rise = test_s && !test_d_ff;

    // An error in the restart cycle still counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_d_ff <= 1'b0;
            bist_ok_ff <= 1'b1;
        end else begin
            test_d_ff <= test_s;
            if (test_s && payload_error) begin
                bist_ok_ff <= 1'b0;
            end else if (test_rise || restart_wr) begin
                bist_ok_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parallel output gating

    logic lclk_d_ff;
    logic lock_out_ff;
    dsoc_pkg::dsoc_pix_type pix_ff;
    logic pclk_out_ff;

    // Data changes on the edge opposite the strobe edge
    wire launch = cfg.strobe_polarity ? (!lclk_s && lclk_d_ff) : (lclk_s && !lclk_d_ff);
    wire active = running && lock_s && !held;
    wire drive_sleep = powered && cfg.sleep_output_choice;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lclk_d_ff <= 1'b0;
            lock_out_ff <= 1'b0;
            pix_ff <= '0;
            pclk_out_ff <= 1'b0;
        end else begin
            lclk_d_ff <= lclk_s;
            lock_out_ff <= running && lock_s;
            pclk_out_ff <= active && lclk_s;
            if (!active) begin
                pix_ff <= '0;
            end else if (launch) begin
                pix_ff <= pix2_ff;
            end
        end
    end

    // Running and locked outputs drive, low while held; otherwise unlocked or asleep follows the sleep choice
    // Enables follow the registered lock so the pins never run ahead of pll_acquired
    // Held and unlocked still obeys the sleep choice; the hold strap forces no drive
    wire oe_all = !powered ? 1'b0 :
        (running && lock_out_ff) ? 1'b1 :
        drive_sleep;

    assign rgb_out = {pix_ff.red, pix_ff.green, pix_ff.blue};
    assign line_sync = pix_ff.line_sync;
    assign frame_sync = pix_ff.frame_sync;
    assign pixel_valid = pix_ff.pixel_valid;
    assign pixel_clock_out = pclk_out_ff;
    assign rgb_oe = oe_all;
    assign sync_oe = oe_all;
    assign pixel_clock_oe = oe_all;
    assign pll_acquired = lock_out_ff;
    assign bist_ok_flag = bist_ok_ff && !(running && held);
    assign pass_oe = powered && (running || cfg.sleep_output_choice);

endmodule // dsoc_strap_ctrl

/* include/dsoc_regs.svh */
// Register offsets, field positions, reset values and strap pin positions
`ifndef DSOC_REGS_SVH
`define DSOC_REGS_SVH

`define DSOC_ADDR_W 12
`define DSOC_OFS_CTRL 12'h000
`define DSOC_OFS_CFG_OVR 12'h004
`define DSOC_OFS_CFG_EFF 12'h008
`define DSOC_OFS_STATUS 12'h00c

`define DSOC_CTRL_RELEASE_B 0
`define DSOC_CTRL_RESTART_B 1

`define DSOC_STAT_LOCK_B 0
`define DSOC_STAT_BIST_OK_B 1
`define DSOC_STAT_POWERED_B 2
`define DSOC_STAT_HELD_B 3
`define DSOC_STAT_OVR_B 4

`define DSOC_CFG_W 21
`define DSOC_CFG_RESET 21'h0
`define DSOC_SYNC_STAGES 2

// Strap positions inside the red, green and blue pin groups
`define DSOC_STR_MODE1_B 6
`define DSOC_STR_MODE0_B 7
`define DSOC_STR_GAIN3_G 7
`define DSOC_STR_GAIN0_G 4
`define DSOC_STR_LOWBAND_B 4
`define DSOC_STR_MAP1_R 1
`define DSOC_STR_MAP0_R 0
`define DSOC_STR_DRATE_B 3
`define DSOC_STR_OSC2_G 2
`define DSOC_STR_OSC0_G 0
`define DSOC_STR_PRATE_B 5
`define DSOC_STR_SLEEP_B 2
`define DSOC_STR_POL_B 1
`define DSOC_STR_SSC3_R 6
`define DSOC_STR_SSC0_R 3

`endif

/* include/dsoc_pkg.sv */
// Types shared by the output and strap control block
package dsoc_pkg;

    typedef struct packed {
        logic [1:0] link_mode;
        logic [1:0] bit_map_choice;
        logic [3:0] rx_gain_boost_setting;
        logic [2:0] pattern_clock_choice;
        logic [3:0] spread_clock_gen;
        logic spread_low_band;
        logic data_edge_rate;
        logic pixclk_edge_rate;
        logic sleep_output_choice;
        logic strobe_polarity;
        logic hold_outputs_zero;
    } dsoc_cfg_type;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic line_sync;
        logic frame_sync;
        logic pixel_valid;
    } dsoc_pix_type;

    typedef enum logic [1:0] {
        DSOC_OFF,
        DSOC_RUN,
        DSOC_SLEEP
    } dsoc_state_type;

endpackage

/* testbench/dsoc_strap_ctrl_monitor.sv */
// Port-level checks for the output and strap control block
`timescale 1ns/1ps
module dsoc_strap_ctrl_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic self_test_on,
    input wire logic payload_error,
    input wire logic psel,
    input wire logic pwrite,
    input wire logic rx_pll_locked,
    input wire logic pll_acquired,
    input wire logic bist_ok_flag,
    input wire logic [23:0] rgb_out,
    input wire logic rgb_oe,
    input wire logic sync_oe,
    input wire logic pixel_clock_oe,
    input wire logic line_sync,
    input wire logic frame_sync,
    input wire logic pixel_valid,
    input wire dsoc_pkg::dsoc_cfg_type cfg_active,
    input wire logic control_filter_on,
    input wire logic spread_band_low
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    sequence unlocked3;
        !pll_acquired [*3];
    endsequence
    // Test enable must have crossed the synchroniser
    sequence test_steady;
        self_test_on && $past(self_test_on, 3) && $past(presetn, 3);
    endsequence
    ////////////////////////////////////////
    a_lock_needs_pll: assert property (!rx_pll_locked [*4] |-> !pll_acquired)
        else $error("lock shown while pll unlocked");
    a_unlock_quiet: assert property (!pll_acquired [*2] |-> rgb_out == 24'h0 && !line_sync
        && !frame_sync && !pixel_valid) else $error("video active while unlocked");
    a_bist_error: assert property (test_steady ##0 payload_error |=> !bist_ok_flag)
        else $error("payload error not flagged");
    a_bist_sticky: assert property ((!bist_ok_flag && !(psel && pwrite)) ##0 test_steady
        |=> !bist_ok_flag) else $error("fail flag cleared itself");
    a_sleep_float: assert property (unlocked3 ##0 !cfg_active.sleep_output_choice
        && !$past(cfg_active.sleep_output_choice) |-> !rgb_oe && !sync_oe && !pixel_clock_oe)
        else $error("outputs driven in tri-state sleep");
    a_sleep_low: assert property (unlocked3 ##0 cfg_active.sleep_output_choice
        && $past(cfg_active.sleep_output_choice) |-> rgb_oe && sync_oe && pixel_clock_oe
        && rgb_out == 24'h0) else $error("outputs not driven low in sleep");
    a_filter_mode: assert property (control_filter_on == (cfg_active.link_mode == 2'h1))
        else $error("filter select wrong");
    a_band_select: assert property (spread_band_low ==
        (cfg_active.spread_clock_gen != 4'h0 && cfg_active.spread_low_band))
        else $error("spread band wrong");
endmodule // dsoc_strap_ctrl_monitor

/* testbench/dsoc_link_model.sv */
// Behavioural recovered-video source on the link side
`timescale 1ns/1ps
module dsoc_link_model (
    input wire logic run,
    output logic rec_pixel_clock,
    output dsoc_pkg::dsoc_pix_type rec_pix,
    output logic rx_pll_locked
);
    int n = 0;
    initial rec_pixel_clock = 1'b0;
    initial rec_pix = '0;
    assign rx_pll_locked = run;
    // Clock stands still while unlocked; idle data keeps changing
    always begin
        #62.5;
        if (run) begin
            rec_pixel_clock = ~rec_pixel_clock;
        end else begin
            rec_pix = ~rec_pix;
        end
        if (run && rec_pixel_clock) begin
            n++;
            rec_pix.red = n[7:0];
            rec_pix.green = n[7:0] ^ 8'h3c;
            rec_pix.blue = ~n[7:0];
            rec_pix.line_sync = n[3];
            rec_pix.pixel_valid = n[1];
            if (n % 130 == 0) rec_pix.frame_sync = ~rec_pix.frame_sync;
        end
    end
endmodule // dsoc_link_model

/* testbench/testbench.sv */
// Directed bench for the output and strap control block
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic powerdown_n = 1'b0;
    logic self_test_on = 1'b0;
    logic payload_error = 1'b0;
    logic run = 1'b0;
    logic pass_strap = 1'b0;
    logic [23:0] straps = 24'h18a59a;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, rec_pixel_clock, rx_pll_locked, pll_acquired, bist_ok_flag;
    logic rgb_oe, line_sync, frame_sync, pixel_valid, sync_oe, pixel_clock_out, pixel_clock_oe;
    logic pass_oe, pass_in, control_filter_on, spread_band_low;
    logic [23:0] rgb_in, rgb_out;
    dsoc_pkg::dsoc_pix_type rec_pix;
    dsoc_pkg::dsoc_cfg_type cfg_active;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    // Shared pins: the driver wins over the strap resistor
    assign rgb_in = rgb_oe ? rgb_out : straps;
    assign pass_in = pass_oe ? bist_ok_flag : pass_strap;
    always #5 pclk = ~pclk;
    dsoc_strap_ctrl dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .powerdown_n(powerdown_n), .self_test_on(self_test_on), .rx_pll_locked(rx_pll_locked),
        .payload_error(payload_error), .rec_pixel_clock(rec_pixel_clock), .rec_pix(rec_pix),
        .rgb_in(rgb_in), .rgb_out(rgb_out), .rgb_oe(rgb_oe), .line_sync(line_sync),
        .frame_sync(frame_sync), .pixel_valid(pixel_valid), .sync_oe(sync_oe),
        .pixel_clock_out(pixel_clock_out), .pixel_clock_oe(pixel_clock_oe),
        .pll_acquired(pll_acquired), .pass_in(pass_in), .bist_ok_flag(bist_ok_flag),
        .pass_oe(pass_oe), .cfg_active(cfg_active), .control_filter_on(control_filter_on),
        .spread_band_low(spread_band_low)
    );
    dsoc_link_model link (
        .run(run), .rec_pixel_clock(rec_pixel_clock), .rec_pix(rec_pix),
        .rx_pll_locked(rx_pll_locked)
    );
    ////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(n, e, rd);
    endtask
    // Data held over a link period must appear by the next rising edge
    // Pixel clock out is high at the link fall and low just after the next rise
    task automatic video_chk();
        logic [26:0] e;
        logic clk_at_fall;
        logic [31:0] got;
        @(negedge rec_pixel_clock);
        e = {rec_pix.line_sync, rec_pix.frame_sync, rec_pix.pixel_valid,
            rec_pix.red, rec_pix.green, rec_pix.blue};
        clk_at_fall = pixel_clock_out;
        @(posedge rec_pixel_clock);
        #1;
        got = {3'h0, clk_at_fall, pixel_clock_out, line_sync, frame_sync, pixel_valid, rgb_out};
        check("video", {5'h2, e}, got);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        check("oe early", 32'h0, {29'h0, rgb_oe, sync_oe, pixel_clock_oe});
        powerdown_n <= 1'b1;
        repeat (10) @(posedge pclk);
        rd_chk("cfg strap", 12'h008, 32'h000954f2);
        check("modes", 32'h3, {30'h0, control_filter_on, spread_band_low});
        run <= 1'b1;
        repeat (60) @(posedge pclk);
        check("lock", 32'h3, {30'h0, pll_acquired, rgb_oe});
        repeat (3) video_chk();
        self_test_on <= 1'b1;
        repeat (6) @(posedge pclk);
        payload_error <= 1'b1;
        @(posedge pclk);
        payload_error <= 1'b0;
        repeat (20) @(posedge pclk);
        check("bist err", 32'h0, {31'h0, bist_ok_flag});
        apb(1'b1, 12'h000, 32'h2);
        repeat (2) @(posedge pclk);
        check("bist restart", 32'h1, {31'h0, bist_ok_flag});
        self_test_on <= 1'b0;
        apb(1'b1, 12'h004, 32'h4);
        rd_chk("cfg ovr", 12'h008, 32'h4);
        check("modes ovr", 32'h0, {30'h0, control_filter_on, spread_band_low});
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", 32'h1, {rd[30:0], err});
        run <= 1'b0;
        repeat (20) @(posedge pclk);
        check("sleep low", 32'h01000000, {6'h0, pll_acquired, rgb_oe, rgb_out});
        powerdown_n <= 1'b0;
        repeat (10) @(posedge pclk);
        rd_chk("cfg pd", 12'h008, 32'h000954f2);
        check("pd oe", 32'h0, {28'h0, rgb_oe, sync_oe, pixel_clock_oe, pass_oe});
        powerdown_n <= 1'b1;
        presetn <= 1'b0;
        pass_strap <= 1'b1;
        straps <= 24'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        run <= 1'b1;
        repeat (60) @(posedge pclk);
        check("held", 32'h03000000, {6'h0, pll_acquired, rgb_oe, rgb_out});
        rd_chk("status", 12'h00c, 32'hf);
        apb(1'b1, 12'h000, 32'h1);
        repeat (20) @(posedge pclk);
        video_chk();
        finish_test();
    end
endmodule // testbench
bind dsoc_strap_ctrl dsoc_strap_ctrl_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .self_test_on(self_test_on), .payload_error(payload_error),
    .psel(psel), .pwrite(pwrite), .rx_pll_locked(rx_pll_locked), .pll_acquired(pll_acquired),
    .bist_ok_flag(bist_ok_flag), .rgb_out(rgb_out), .rgb_oe(rgb_oe), .sync_oe(sync_oe),
    .pixel_clock_oe(pixel_clock_oe), .line_sync(line_sync), .frame_sync(frame_sync),
    .pixel_valid(pixel_valid), .cfg_active(cfg_active), .control_filter_on(control_filter_on),
    .spread_band_low(spread_band_low)
);
